// file: verilog/pfi_defs.svh
// constants for the program flow and indirect access block
`ifndef PFI_DEFS_SVH
`define PFI_DEFS_SVH
`define PFI_OFF_INTERRUPT_CONTROL 8'h0B
`define PFI_OFF_PC_LOW_BYTE       8'h02
`define PFI_OFF_POINTER_REGISTER  8'h04
`define PFI_OFF_PC_HIGH_LATCH     8'h0A
`define PFI_OFF_INDIRECT_PORT     8'h00
`define PFI_OFF_STACK_CMD         8'h10
`define PFI_OFF_PC_STATUS         8'h11
`define PFI_OFF_EVENT_IN          8'h12
`define PFI_BIT_GIE   7
`define PFI_BIT_EEPROM_DONE_IRQ_ENABLE  6
`define PFI_BIT_TIMER_OVERFLOW_IRQ_ENABLE  5
`define PFI_BIT_INTE  4
`define PFI_BIT_PORT_CHANGE_IRQ_ENABLE  3
`define PFI_BIT_TIMER_OVERFLOW_FLAG  2
`define PFI_BIT_EXT_PIN_IRQ_FLAG  1
`define PFI_BIT_PORT_CHANGE_FLAG  0
`define PFI_INTERRUPT_CONTROL_RESET 8'h00
`define PFI_PC_RESET     13'h0000
`define PFI_IRQ_VECTOR   13'h0004
`define PFI_STACK_DEPTH  8
`define PFI_PC_WIDTH     13
`endif

// file: verilog/pfi_pkg.sv
// types for the program flow and indirect access block
package pfi_pkg;
    typedef enum logic [2:0] {
        PFI_OP_NONE,
        PFI_OP_CALL,
        PFI_OP_JUMP,
        PFI_OP_RETURN,
        PFI_OP_IRQ_ACK,
        PFI_OP_STEP
    } pfi_op_t;
    typedef struct packed {
        logic       ext_pin;
        logic       timer_ovf;
        logic       eeprom_done;
        logic [3:0] portb_hi;
    } pfi_events_t;
endpackage

// file: verilog/pfi_core.sv
// program counter, return stack, indirect access and interrupt control registers
`timescale 1ns/10ps
`include "pfi_defs.svh"
module pfi_core
    import pfi_pkg::*;
#(
    parameter int DEPTH = `PFI_STACK_DEPTH
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // execution unit side
    input  wire pfi_op_t     op,
    input  wire logic [10:0] target,
    input  wire pfi_events_t events,
    input  wire logic        indirect_bank_select,
    output logic      [12:0] pc,
    output logic      [8:0]  indirect_address,
    output logic             irq_request
);
    localparam int PW = `PFI_PC_WIDTH;
    localparam int SW = $clog2(DEPTH);

    logic [7:0]    interrupt_control;
    logic [7:0]    pc_high_latch;
    logic [7:0]    pointer_register;
    logic [PW-1:0] stack_mem [DEPTH];
    logic [SW-1:0] stack_ptr;
    logic [3:0]    portb_last;
    logic          ack_pending;

    // bus decode, answer comes one cycle after the request
    wire req        = (read | write) & ~ack_pending;
    wire wr_take    = write & ack_pending;
    wire sel_interrupt_control = address == `PFI_OFF_INTERRUPT_CONTROL;
    wire sel_pcl    = address == `PFI_OFF_PC_LOW_BYTE;
    wire sel_ptr    = address == `PFI_OFF_POINTER_REGISTER;
    wire sel_pch    = address == `PFI_OFF_PC_HIGH_LATCH;
    wire sel_ind    = address == `PFI_OFF_INDIRECT_PORT;
    wire sel_stk    = address == `PFI_OFF_STACK_CMD;
    wire sel_evt    = address == `PFI_OFF_EVENT_IN;
    assign waitrequest = (read | write) & ~ack_pending;

    // indirect redirection: indirect address formed from bank bit and pointer, effective address from the pointer alone
    assign indirect_address = {indirect_bank_select, pointer_register};
    wire ind_self = pointer_register == `PFI_OFF_INDIRECT_PORT;
    wire [7:0] ind_target = ind_self ? 8'hFF : pointer_register;
    wire [7:0] eff_addr   = sel_ind ? ind_target : address;
    // writes to the indirect port with pointer zero become no-ops
    wire eff_wr  = wr_take & ~(sel_ind & ind_self);
    wire w_intc  = eff_wr & (eff_addr == `PFI_OFF_INTERRUPT_CONTROL);
    wire w_pcl   = eff_wr & (eff_addr == `PFI_OFF_PC_LOW_BYTE);
    wire w_ptr   = eff_wr & (eff_addr == `PFI_OFF_POINTER_REGISTER);
    wire w_pch   = eff_wr & (eff_addr == `PFI_OFF_PC_HIGH_LATCH);
    wire w_stk   = wr_take & sel_stk;
    wire w_evt   = wr_take & sel_evt;

    // software may also drive stack operations for testing through a command word
    wire pfi_op_t eff_op = w_stk ? pfi_op_t'(writedata[2:0]) : op;
    wire do_push = (eff_op == PFI_OP_CALL) | (eff_op == PFI_OP_IRQ_ACK);
    wire do_pop  = eff_op == PFI_OP_RETURN;
    wire [SW-1:0] pop_ptr = stack_ptr - SW'(1);

    // software-injected events and pin events share the flag path
    wire ev_ext   = events.ext_pin | (w_evt & writedata[0]);
    wire ev_tmr   = events.timer_ovf | (w_evt & writedata[1]);
    wire ev_port  = (events.portb_hi != portb_last) | (w_evt & writedata[2]);
    wire ev_ee    = events.eeprom_done;

    // next pc: latch bits 7:5 have no place in the 13-bit counter
    logic [PW-1:0] next_pc;
    always_comb
    begin
        next_pc = pc;
        if (w_pcl)
            next_pc = {pc_high_latch[4:0], writedata[7:0]};
        else if (eff_op == PFI_OP_CALL || eff_op == PFI_OP_JUMP)
            next_pc = {pc_high_latch[4:3], target};
        else if (do_pop)
            next_pc = stack_mem[pop_ptr];
        else if (eff_op == PFI_OP_IRQ_ACK)
            next_pc = `PFI_IRQ_VECTOR;
        else if (eff_op == PFI_OP_STEP)
            next_pc = pc + 13'h0001;
    end

    // the stored value for a call is the return address, one past pc
    wire [PW-1:0] push_val = (eff_op == PFI_OP_CALL) ? pc + 13'h0001 : pc;

    // bus handshake
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ack_pending <= 1'b0;
        else
            ack_pending <= req;
    end

    // program counter
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pc <= `PFI_PC_RESET;
        else
            pc <= next_pc;
    end

    // circular stack, pointer free running with no wrap status
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            stack_ptr <= '0;
        else if (do_push)
            stack_ptr <= stack_ptr + SW'(1);
        else if (do_pop)
            stack_ptr <= pop_ptr;
    end

    // stack storage, one entry per level
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_stack
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    stack_mem[gi] <= '0;
                else if (do_push && stack_ptr == SW'(gi))
                    stack_mem[gi] <= push_val;
            end
        end
    endgenerate

    // latch and pointer registers; stack operations never touch the latch
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pc_high_latch    <= 8'h00;
            pointer_register <= 8'h00;
        end
        else
        begin
            if (w_pch)
                pc_high_latch <= writedata[7:0];
            if (w_ptr)
                pointer_register <= writedata[7:0];
        end
    end

    // remembered port state for change detection
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            portb_last <= 4'h0;
        else
            portb_last <= events.portb_hi;
    end

    // interrupt control: enables written, flags set win over clear
    logic [7:0] next_interrupt_control;
    always_comb
    begin
        next_interrupt_control = interrupt_control;
        if (w_intc)
            next_interrupt_control = writedata[7:0];
        if (ev_tmr)
            next_interrupt_control[`PFI_BIT_TIMER_OVERFLOW_FLAG] = 1'b1;
        if (ev_ext)
            next_interrupt_control[`PFI_BIT_EXT_PIN_IRQ_FLAG] = 1'b1;
        if (ev_port)
            next_interrupt_control[`PFI_BIT_PORT_CHANGE_FLAG] = 1'b1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            interrupt_control <= `PFI_INTERRUPT_CONTROL_RESET;
        else
            interrupt_control <= next_interrupt_control;
    end

    // eeprom done has no flag bit in this block; it raises a request when enabled
    wire any_src = (interrupt_control[`PFI_BIT_EEPROM_DONE_IRQ_ENABLE] & ev_ee)
                 | (interrupt_control[`PFI_BIT_TIMER_OVERFLOW_IRQ_ENABLE] & interrupt_control[`PFI_BIT_TIMER_OVERFLOW_FLAG])
                 | (interrupt_control[`PFI_BIT_INTE] & interrupt_control[`PFI_BIT_EXT_PIN_IRQ_FLAG])
                 | (interrupt_control[`PFI_BIT_PORT_CHANGE_IRQ_ENABLE] & interrupt_control[`PFI_BIT_PORT_CHANGE_FLAG]);
    assign irq_request = interrupt_control[`PFI_BIT_GIE] & any_src;

    // read mux, unmapped addresses read zero
    logic [7:0] next_rd;
    always_comb
    begin
        next_rd = 8'h00;
        if (eff_addr == `PFI_OFF_INTERRUPT_CONTROL)
            next_rd = interrupt_control;
        else if (eff_addr == `PFI_OFF_PC_LOW_BYTE)
            next_rd = pc[7:0];
        else if (eff_addr == `PFI_OFF_POINTER_REGISTER)
            next_rd = pointer_register;
        else if (eff_addr == `PFI_OFF_PC_HIGH_LATCH)
            next_rd = pc_high_latch;
        else if (!sel_ind && eff_addr == `PFI_OFF_PC_STATUS)
            next_rd = {3'h0, pc[12:8]};
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            readdata <= 32'h0000_0000;
        else if (req && read)
            readdata <= {24'h00_0000, next_rd};
    end

    // checks
    a_push_advances: assert property (@(posedge clk) disable iff (reset)
        (do_push && !w_pcl) |=> stack_ptr == $past(stack_ptr) + SW'(1))
        else $error("stack pointer did not advance on push");
    a_pop_restores: assert property (@(posedge clk) disable iff (reset)
        (do_pop && !w_pcl) |=> pc == $past(stack_mem[pop_ptr]))
        else $error("pop did not restore pc");
    a_latch_kept: assert property (@(posedge clk) disable iff (reset)
        ((do_push || do_pop) && !w_pch) |=> $stable(pc_high_latch))
        else $error("latch changed on stack op");
    a_pcl_write: assert property (@(posedge clk) disable iff (reset)
        w_pcl |=> pc == {$past(pc_high_latch[4:0]), $past(writedata[7:0])})
        else $error("pc load from latch wrong");
    a_flag_sets: assert property (@(posedge clk) disable iff (reset)
        ev_ext |=> interrupt_control[`PFI_BIT_EXT_PIN_IRQ_FLAG])
        else $error("external flag not set");
    a_irq_gate: assert property (@(posedge clk) disable iff (reset)
        !interrupt_control[`PFI_BIT_GIE] |-> !irq_request)
        else $error("request without global enable");
    a_ind_zero: assert property (@(posedge clk) disable iff (reset)
        (req && read && sel_ind && ind_self) |=> readdata == 32'h0)
        else $error("indirect self read not zero");
    a_ind_selfwr: assert property (@(posedge clk) disable iff (reset)
        (wr_take && sel_ind && ind_self && !ev_ext && !ev_tmr && !ev_port)
        |=> $stable(interrupt_control) && $stable(pointer_register))
        else $error("indirect self write changed state");

    // interrupt enables and flags; only a register write may drop a flag
    a_eeprom_enable: assert property (@(posedge clk) disable iff (reset)
        (interrupt_control[`PFI_BIT_GIE] && interrupt_control[`PFI_BIT_EEPROM_DONE_IRQ_ENABLE] && ev_ee)
        |-> irq_request)
        else $error("eeprom done request missing");
    a_timer_enable: assert property (@(posedge clk) disable iff (reset)
        (interrupt_control[`PFI_BIT_GIE] && interrupt_control[`PFI_BIT_TIMER_OVERFLOW_IRQ_ENABLE]
        && interrupt_control[`PFI_BIT_TIMER_OVERFLOW_FLAG]) |-> irq_request)
        else $error("timer overflow request missing");
    a_ext_flag_hold: assert property (@(posedge clk) disable iff (reset)
        (interrupt_control[`PFI_BIT_EXT_PIN_IRQ_FLAG] && !w_intc) |=> interrupt_control[`PFI_BIT_EXT_PIN_IRQ_FLAG])
        else $error("external flag dropped without a write");
    a_timer_flag: assert property (@(posedge clk) disable iff (reset)
        ev_tmr |=> interrupt_control[`PFI_BIT_TIMER_OVERFLOW_FLAG])
        else $error("timer flag not set");
    a_port_flag_set: assert property (@(posedge clk) disable iff (reset)
        ev_port |=> interrupt_control[`PFI_BIT_PORT_CHANGE_FLAG])
        else $error("port change flag not set");
    a_port_flag_hold: assert property (@(posedge clk) disable iff (reset)
        (interrupt_control[`PFI_BIT_PORT_CHANGE_FLAG] && !w_intc) |=> interrupt_control[`PFI_BIT_PORT_CHANGE_FLAG])
        else $error("port change flag dropped without a write");
    a_intc_write: assert property (@(posedge clk) disable iff (reset)
        (wr_take && sel_interrupt_control && !ev_ext && !ev_tmr && !ev_port)
        |=> interrupt_control == $past(writedata[7:0]))
        else $error("control register write lost");

    // program counter loads
    a_pcl_direct: assert property (@(posedge clk) disable iff (reset)
        (wr_take && sel_pcl) |=> pc[7:0] == $past(writedata[7:0]))
        else $error("low byte write not taken");
    a_pc_hold: assert property (@(posedge clk) disable iff (reset)
        (eff_op == PFI_OP_NONE && !w_pcl) |=> $stable(pc))
        else $error("pc moved without a cause");
    a_step_adds: assert property (@(posedge clk) disable iff (reset)
        (eff_op == PFI_OP_STEP && !w_pcl) |=> pc == $past(pc) + 13'h0001)
        else $error("step did not advance pc");
    a_latch_write: assert property (@(posedge clk) disable iff (reset)
        (wr_take && sel_pch) |=> pc_high_latch == $past(writedata[7:0]))
        else $error("high latch write not taken");
    a_jump_target: assert property (@(posedge clk) disable iff (reset)
        ((eff_op == PFI_OP_JUMP || eff_op == PFI_OP_CALL) && !w_pcl)
        |=> pc == {$past(pc_high_latch[4:3]), $past(target)})
        else $error("branch target wrong");
    a_ack_vector: assert property (@(posedge clk) disable iff (reset)
        (eff_op == PFI_OP_IRQ_ACK && !w_pcl) |=> pc == `PFI_IRQ_VECTOR)
        else $error("acknowledge did not reach the vector");
    a_latch_only_bus: assert property (@(posedge clk) disable iff (reset)
        !w_pch |=> $stable(pc_high_latch))
        else $error("high latch changed without a write");

    // stack contents and pointer
    a_call_push: assert property (@(posedge clk) disable iff (reset)
        (eff_op == PFI_OP_CALL) |=> stack_mem[$past(stack_ptr)] == $past(pc) + 13'h0001)
        else $error("call stored wrong return address");
    a_ack_push: assert property (@(posedge clk) disable iff (reset)
        (eff_op == PFI_OP_IRQ_ACK) |=> stack_mem[$past(stack_ptr)] == $past(pc))
        else $error("acknowledge stored wrong pc");
    a_ptr_wraps: assert property (@(posedge clk) disable iff (reset)
        (do_push && stack_ptr == SW'(DEPTH - 1)) |=> stack_ptr == '0)
        else $error("stack pointer did not wrap");
    a_pop_retreats: assert property (@(posedge clk) disable iff (reset)
        do_pop |=> stack_ptr == $past(stack_ptr) - SW'(1))
        else $error("stack pointer did not retreat on pop");

    // indirect access
    a_ind_redirect: assert property (@(posedge clk) disable iff (reset)
        (req && read && sel_ind && pointer_register == `PFI_OFF_INTERRUPT_CONTROL)
        |=> readdata[7:0] == $past(interrupt_control))
        else $error("indirect read not redirected");
    a_pointer_load: assert property (@(posedge clk) disable iff (reset)
        (wr_take && sel_ptr) |=> pointer_register == $past(writedata[7:0]))
        else $error("pointer write not taken");
    a_self_wr_pc: assert property (@(posedge clk) disable iff (reset)
        (wr_take && sel_ind && ind_self && eff_op == PFI_OP_NONE) |=> $stable(pc))
        else $error("indirect self write moved pc");
endmodule

// file: tb/pfi_exec_model.sv
// execution unit model that drives the control side of the block
`timescale 1ns/10ps
module pfi_exec_model
    import pfi_pkg::*;
(
    // clock
    input  wire logic        clk,
    // control to the block
    output pfi_op_t          op,
    output logic      [10:0] target,
    output logic             indirect_bank_select
);
    // idle at start, bank bit clear as the device leaves it unused
    initial
    begin
        op = PFI_OP_NONE;
        target = 11'h000;
        indirect_bank_select = 1'b0;
    end
    // one op for one cycle; target turned over once idle so no stale value lingers
    // tables that cross a 256-word block reload the latch first
    task automatic issue(input pfi_op_t o, input logic [10:0] t);
    begin
        @(posedge clk);
        op <= o;
        target <= t;
        @(posedge clk);
        op <= PFI_OP_NONE;
        target <= ~t;
    end
    endtask
    // bank bit only feeds the indirect address
    task automatic set_bank(input logic b);
    begin
        @(posedge clk);
        indirect_bank_select <= b;
    end
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the program flow and indirect block
`timescale 1ns/10ps
`include "pfi_defs.svh"
module testbench import pfi_pkg::*;;
    logic        clk;
    logic        reset;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    pfi_op_t     op;
    logic [10:0] target;
    pfi_events_t events;
    logic        bank;
    logic [12:0] pc;
    logic [8:0]  indirect_address;
    logic        irq_request;
    logic [31:0] rd;
    logic        irq_seen;
    int          errors;
    int          checks_done;

    pfi_exec_model exec (.clk(clk), .op(op), .target(target), .indirect_bank_select(bank));
    pfi_core uut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .op(op),
        .target(target), .events(events), .indirect_bank_select(bank), .pc(pc),
        .indirect_address(indirect_address), .irq_request(irq_request));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report;
    begin
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    // one avalon access; held until waitrequest is seen low, data taken then
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
    begin
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20)
        begin
            errors++;
            $display("BAD bus waitrequest expected 0 seen %b", waitrequest);
            final_report;
        end
    end
    endtask

    task automatic pcchk(input string what, input logic [12:0] exp);
    begin
        @(negedge clk);
        chk(what, {19'h0, exp}, {19'h0, pc});
    end
    endtask

    // request looked at mid-cycle, after the write edge has settled
    task automatic irqchk(input string what, input logic exp);
    begin
        @(negedge clk);
        chk(what, {31'h0, exp}, {31'h0, irq_request});
    end
    endtask

    // ext, timer, eeprom pulse for one cycle; irq sampled mid-pulse
    task automatic pulse(input logic [2:0] p);
    begin
        @(posedge clk);
        events <= {p, events.portb_hi};
        @(negedge clk);
        irq_seen = irq_request;
        @(posedge clk);
        events <= {3'b000, events.portb_hi};
    end
    endtask

    task automatic t_reset;
    begin
        bus(1'b0, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        chk("interrupt_control", 32'h0, rd & 32'hFFFFFFFE);
        pcchk("pc", 13'h0000);
        bus(1'b0, 8'h3F, 8'h00);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
    end
    endtask

    task automatic t_pc;
    begin
        bus(1'b1, `PFI_OFF_PC_HIGH_LATCH, 8'h1F);
        bus(1'b1, `PFI_OFF_PC_LOW_BYTE, 8'h34);
        pcchk("pc load", 13'h1F34);
        bus(1'b0, `PFI_OFF_PC_LOW_BYTE, 8'h00);
        chk("pcl", 32'h34, rd);
        bus(1'b1, `PFI_OFF_PC_HIGH_LATCH, 8'h07);
        exec.issue(PFI_OP_JUMP, 11'h5A5);
        pcchk("jump", 13'h05A5);
        exec.issue(PFI_OP_CALL, 11'h123);
        pcchk("call", 13'h0123);
        exec.issue(PFI_OP_RETURN, 11'h000);
        pcchk("return", 13'h05A6);
        bus(1'b0, `PFI_OFF_PC_HIGH_LATCH, 8'h00);
        chk("latch", 32'h07, rd);
        exec.issue(PFI_OP_IRQ_ACK, 11'h000);
        pcchk("vector", `PFI_IRQ_VECTOR);
        exec.issue(PFI_OP_RETURN, 11'h000);
        pcchk("irq return", 13'h05A6);
        $display("test pc done");
    end
    endtask

    // nine pushes then nine pops: the ninth of each lands on the first slot
    task automatic t_wrap;
    begin
        for (int k = 0; k < 9; k++)
        begin
            exec.issue(PFI_OP_JUMP, 11'(256 + 16 * k));
            exec.issue(PFI_OP_CALL, 11'h700);
        end
        for (int i = 0; i < 9; i++)
        begin
            exec.issue(PFI_OP_RETURN, 11'h000);
            pcchk("pop", 13'(257 + 16 * (8 - i % 8)));
        end
        $display("test wrap done");
    end
    endtask

    task automatic t_irq;
    begin
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        pulse(3'b010);
        pulse(3'b100);
        @(posedge clk);
        events.portb_hi <= 4'h8;
        bus(1'b0, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        chk("flags", 32'h07, rd);
        irqchk("irq off", 1'b0);
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'hA7);
        irqchk("irq timer", 1'b1);
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'h87);
        irqchk("irq masked", 1'b0);
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'h80);
        bus(1'b0, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        chk("cleared", 32'h80, rd);
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'hC0);
        pulse(3'b001);
        chk("irq eeprom", 32'h1, {31'h0, irq_seen});
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'h80);
        pulse(3'b001);
        chk("eeprom off", 32'h0, {31'h0, irq_seen});
        $display("test irq done");
    end
    endtask

    task automatic t_ind;
    begin
        bus(1'b1, `PFI_OFF_POINTER_REGISTER, `PFI_OFF_INTERRUPT_CONTROL);
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'h30);
        bus(1'b0, `PFI_OFF_INDIRECT_PORT, 8'h00);
        chk("ind read", 32'h30, rd);
        chk("ind addr", 32'h00B, {23'h0, indirect_address});
        exec.set_bank(1'b1);
        @(negedge clk);
        chk("ind bank", 32'h10B, {23'h0, indirect_address});
        bus(1'b1, `PFI_OFF_INDIRECT_PORT, 8'h48);
        bus(1'b0, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        chk("ind write", 32'h48, rd);
        bus(1'b1, `PFI_OFF_POINTER_REGISTER, 8'h00);
        bus(1'b0, `PFI_OFF_INDIRECT_PORT, 8'h00);
        chk("self read", 32'h0, rd);
        bus(1'b1, `PFI_OFF_INDIRECT_PORT, 8'hFF);
        bus(1'b0, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        chk("self write", 32'h48, rd);
        $display("test indirect done");
    end
    endtask

    // step, stack command word, pc status and injected events
    task automatic t_cmd;
    begin
        bus(1'b1, `PFI_OFF_PC_LOW_BYTE, 8'h40);
        exec.issue(PFI_OP_STEP, 11'h000);
        pcchk("step", 13'h0741);
        exec.issue(PFI_OP_CALL, 11'h2C0);
        bus(1'b1, `PFI_OFF_STACK_CMD, 8'(PFI_OP_RETURN));
        pcchk("cmd pop", 13'h0742);
        bus(1'b0, `PFI_OFF_PC_STATUS, 8'h00);
        chk("pc high", 32'h07, rd);
        bus(1'b1, `PFI_OFF_INTERRUPT_CONTROL, 8'h90);
        irqchk("irq idle", 1'b0);
        bus(1'b1, `PFI_OFF_EVENT_IN, 8'h01);
        irqchk("irq ext", 1'b1);
        bus(1'b1, `PFI_OFF_EVENT_IN, 8'h06);
        bus(1'b0, `PFI_OFF_INTERRUPT_CONTROL, 8'h00);
        chk("injected", 32'h97, rd);
        $display("test command done");
    end
    endtask

    // reset for four cycles, then the scenarios in turn
    initial
    begin
        errors = 0;
        checks_done = 0;
        reset = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        events = '0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_pc;
        t_wrap;
        t_irq;
        t_ind;
        t_cmd;
        final_report;
    end
endmodule
